/* verilog/ees_params.svh */
// offsets, field positions, reset values and counts for the stop block
`ifndef EES_PARAMS_SVH
`define EES_PARAMS_SVH
// register byte offsets
`define EES_CMD_OFS       8'h00
`define EES_EXT_STS_OFS   8'h04
`define EES_ERR_CAUSE_OFS 8'h08
`define EES_IRQ_MASK_OFS  8'h0C
`define EES_AXIS_BASE     8'h20
`define EES_AXIS_STRIDE   8'h08
`define EES_ENV1_OFS      8'h04
// field positions
`define EES_LINE_EN_BIT   24
`define EES_AUTO_OUT_BIT  25
`define EES_STOP_MTH_BIT  19
`define EES_LINE_STS_BIT  6
`define EES_EMG_STS_BIT   7
`define EES_LINE_ERR_BIT  8
`define EES_EMG_ERR_BIT   9
// command codes
`define EES_CMD_EMG       8'h05
`define EES_CMD_SIM_STOP  8'h07
`define EES_CMD_AXIS_STOP 8'h49
// reset values
`define EES_MODE_RST      32'h0000_0000
`define EES_ENV1_RST      32'h0000_0000
`define EES_MASK_RST      32'h0000_0000
// one-shot length in reference clocks
`define EES_PULSE_CYCLES  4'h8
`endif

/* verilog/ees_pkg.sv */
// types shared by the stop block
package ees_pkg;
  // one-shot driver states
  typedef enum logic [1:0] {
    PS_IDLE  = 2'b01,
    PS_DRIVE = 2'b10
  } ees_pulse_state_type;
  // axi response codes
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } ees_resp_type;
endpackage

/* verilog/ees_top.sv */
// external and emergency stop control with an axi4-lite register slave
// Functional notes
// R1: stop line honoured only with enable bit 24
// R2: stop method bit 19 picks immediate/decel
// R3: constant-speed axes always stop immediately
// R4: stop line is active low, fixed
// R5: stop line shared, driven and received
// R6: simultaneous-stop command drives 8-clock low pulse
// R7: error stop with bit 25 drives pulse
// R8: external drivers hold line low 4 clocks
// R9: per-axis stop command leaves line alone
// R10: line level in extension status bit 6
// R11: line stop sets error cause bit 8
// R12: emergency input or command 05h stops all
// R13: no axis runs while emergency low
// R14: emergency stop raises the interrupt
// R15: emergency level in extension status bit 7
// R16: emergency stop sets error cause bit 9
// R17: emergency input is active low, fixed
// R18: software re-homes after emergency stop
// R19: line driven only low, else released
`timescale 1ns/10ps
`include "ees_params.svh"
module ees_top #(
  parameter int NUM_AXES = 4
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // shared stop line pin, open drain
  input  wire logic                shared_stop_line_i,
  output logic                     shared_stop_line_o,
  output logic                     shared_stop_line_oe,
  // emergency input pin
  input  wire logic                emergency_input_n,
  // axis side
  input  wire logic [NUM_AXES-1:0] axis_running,
  input  wire logic [NUM_AXES-1:0] axis_high_speed,
  input  wire logic [NUM_AXES-1:0] axis_error_stop,
  output logic [NUM_AXES-1:0]      stop_immediate,
  output logic [NUM_AXES-1:0]      stop_decel,
  output logic                     start_inhibit,
  // interrupt
  output logic                     irq
);

  // register storage
  logic [31:0] mode_reg [NUM_AXES];   // axis_operation_mode
  logic [31:0] env1_reg [NUM_AXES];   // environment_setting_one
  logic [31:0] err_reg;               // error_cause, sticky
  logic [31:0] mask_reg;              // interrupt mask
  // write channel holding
  logic [7:0]  aw_addr_reg;
  logic        aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_full_reg;
  logic        wr_fire;
  logic [31:0] wmask;
  // read decode
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        rd_fire;
  // command strobes
  logic        cmd_wr;
  logic        cmd_sim_stop;
  logic        cmd_emg;
  logic        cmd_axis_stop;
  // pin synchronisers and filtered levels
  logic        line_s1, line_s2, line_s3;
  logic        emg_s1, emg_s2, emg_s3;
  logic        line_lvl_reg;          // filtered pin level
  logic        emg_lvl_reg;
  logic        line_act_reg;          // asserted, i.e. low
  logic        emg_act_reg;
  logic        line_rise;
  logic        emg_event;
  // per-axis triggers
  logic [NUM_AXES-1:0] line_trig;
  logic [NUM_AXES-1:0] auto_req;
  // one-shot driver
  ees_pkg::ees_pulse_state_type ps_reg;
  logic [3:0]  pulse_cnt_reg;
  logic        pulse_req;

  // write happens once address and data are both held
  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                  {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // write address channel, taken independently of data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_full_reg <= 1'b0;
    end
    else
    begin
      // ready returns only when the holding slot is free
      s_axi_awready <= !aw_full_reg;
    end
  end

  // write data channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (wr_fire)
    begin
      w_full_reg <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_full_reg;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ees_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= ees_pkg::RESP_SLVERR;
      if (aw_addr_reg == `EES_CMD_OFS ||
          aw_addr_reg == `EES_IRQ_MASK_OFS ||
          aw_addr_reg == `EES_EXT_STS_OFS ||
          aw_addr_reg == `EES_ERR_CAUSE_OFS)
        s_axi_bresp <= ees_pkg::RESP_OKAY;
      for (int i = 0; i < NUM_AXES; i++)
      begin
        if (aw_addr_reg == 8'(`EES_AXIS_BASE + `EES_AXIS_STRIDE * i) ||
            aw_addr_reg == 8'(`EES_AXIS_BASE + `EES_AXIS_STRIDE * i
                              + `EES_ENV1_OFS))
          s_axi_bresp <= ees_pkg::RESP_OKAY;
      end
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // command register: write-only strobes, code in byte 0, axes in byte 1
  assign cmd_wr = wr_fire && aw_addr_reg == `EES_CMD_OFS && w_strb_reg[0];
  assign cmd_sim_stop  = cmd_wr && w_data_reg[7:0] == `EES_CMD_SIM_STOP;
  assign cmd_emg       = cmd_wr && w_data_reg[7:0] == `EES_CMD_EMG;
  assign cmd_axis_stop = cmd_wr && w_data_reg[7:0] == `EES_CMD_AXIS_STOP;

  // interrupt mask register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_reg <= `EES_MASK_RST;
    else if (wr_fire && aw_addr_reg == `EES_IRQ_MASK_OFS)
      mask_reg <= (mask_reg & ~wmask) | (w_data_reg & wmask);
  end

  // read data mux, looked up straight from the address
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b0;
    case (s_axi_araddr)
      `EES_CMD_OFS:
        rd_ok = 1'b1;
      `EES_EXT_STS_OFS:
      begin
        rd_ok = 1'b1;
        rd_data[`EES_LINE_STS_BIT] = line_act_reg;  // R10
        rd_data[`EES_EMG_STS_BIT]  = emg_act_reg;   // R15
      end
      `EES_ERR_CAUSE_OFS:
      begin
        rd_ok   = 1'b1;
        rd_data = err_reg;
      end
      `EES_IRQ_MASK_OFS:
      begin
        rd_ok   = 1'b1;
        rd_data = mask_reg;
      end
      default:
      begin
        // axis registers are write-only and read back as zero
        for (int i = 0; i < NUM_AXES; i++)
        begin
          if (s_axi_araddr == 8'(`EES_AXIS_BASE + `EES_AXIS_STRIDE * i) ||
              s_axi_araddr == 8'(`EES_AXIS_BASE + `EES_AXIS_STRIDE * i
                                 + `EES_ENV1_OFS))
            rd_ok = 1'b1;
        end
      end
    endcase
  end

  // read channel: one read in flight, data registered at acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ees_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_ok ? ees_pkg::RESP_OKAY : ees_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
    begin
      s_axi_arready <= 1'b1;
    end
  end

  // pin synchronisers; a level only changes once stages two and three
  // agree, which also drops single-clock glitches on the shared wire
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {line_s1, line_s2, line_s3} <= 3'b111;
      {emg_s1, emg_s2, emg_s3}    <= 3'b111;
      line_lvl_reg <= 1'b1;
      emg_lvl_reg  <= 1'b1;
    end
    else
    begin
      line_s1 <= shared_stop_line_i;
      line_s2 <= line_s1;
      line_s3 <= line_s2;
      emg_s1  <= emergency_input_n;
      emg_s2  <= emg_s1;
      emg_s3  <= emg_s2;
      if (line_s2 == line_s3)
        line_lvl_reg <= line_s3;
      if (emg_s2 == emg_s3)
        emg_lvl_reg <= emg_s3;
    end
  end

  // asserted flags; polarity is fixed active low with no invert option
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_act_reg <= 1'b0;
      emg_act_reg  <= 1'b0;
    end
    else
    begin
      line_act_reg <= !line_lvl_reg;  // R4 R5
      emg_act_reg  <= !emg_lvl_reg;   // R17
    end
  end

  // edge events; our own pulse returns here too and stops local axes
  assign line_rise = !line_lvl_reg && !line_act_reg;
  assign emg_event = (!emg_lvl_reg && !emg_act_reg) || cmd_emg;  // R12

  // per-axis configuration, stop requests and triggers
  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++)
    begin : axis_gen
      localparam logic [7:0] MODE_ADDR =
        8'(`EES_AXIS_BASE + `EES_AXIS_STRIDE * g);
      localparam logic [7:0] ENV1_ADDR = 8'(MODE_ADDR + `EES_ENV1_OFS);

      // configuration registers
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          mode_reg[g] <= `EES_MODE_RST;
          env1_reg[g] <= `EES_ENV1_RST;
        end
        else if (wr_fire && aw_addr_reg == MODE_ADDR)
          mode_reg[g] <= (mode_reg[g] & ~wmask) | (w_data_reg & wmask);
        else if (wr_fire && aw_addr_reg == ENV1_ADDR)
          env1_reg[g] <= (env1_reg[g] & ~wmask) | (w_data_reg & wmask);
      end

      // line stop only for enabled, running axes
      assign line_trig[g] = line_rise && axis_running[g]
                            && mode_reg[g][`EES_LINE_EN_BIT];  // R1
      assign auto_req[g]  = axis_error_stop[g]
                            && mode_reg[g][`EES_AUTO_OUT_BIT];  // R7

      // stop outputs, one-cycle pulses except immediate held on running axes while an emergency is active; an emergency wins over decel
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          stop_immediate[g] <= 1'b0;
          stop_decel[g]     <= 1'b0;
        end
        else
        begin
          stop_immediate[g] <=
            emg_event                                          // R12
            || (emg_act_reg && axis_running[g])                // R13
            || (cmd_axis_stop && w_strb_reg[1]
                && w_data_reg[8 + g])                          // R9
            || (line_trig[g] && (!env1_reg[g][`EES_STOP_MTH_BIT]
                || !axis_high_speed[g]));                      // R2 R3
          stop_decel[g] <= line_trig[g] && !emg_event
            && !emg_act_reg && axis_high_speed[g]
            && env1_reg[g][`EES_STOP_MTH_BIT];                 // R2 R3
        end
      end

      a_line_stops: assert property (  // R1
        @(posedge aclk) disable iff (!aresetn)
        line_trig[g] |=> stop_immediate[g] || stop_decel[g])
        else $error("enabled axis missed a stop line event");
      a_const_speed: assert property (  // R3
        @(posedge aclk) disable iff (!aresetn)
        line_trig[g] && !axis_high_speed[g] |=> stop_immediate[g]
        && !stop_decel[g])
        else $error("constant speed axis did not stop at once");
      a_decel_pick: assert property (  // R2
        @(posedge aclk) disable iff (!aresetn)
        stop_decel[g] |-> $past(mode_reg[g][`EES_LINE_EN_BIT])
        && $past(env1_reg[g][`EES_STOP_MTH_BIT]))
        else $error("deceleration stop without its settings");
    end
  endgenerate

  // one-shot driver: a request while driving is absorbed, not stretched
  assign pulse_req = cmd_sim_stop || (|auto_req);  // R6 R7
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ps_reg        <= ees_pkg::PS_IDLE;
      pulse_cnt_reg <= 4'h0;
    end
    else
    begin
      case (ps_reg)
        ees_pkg::PS_IDLE:
          if (pulse_req)
          begin
            ps_reg        <= ees_pkg::PS_DRIVE;
            pulse_cnt_reg <= `EES_PULSE_CYCLES - 4'h1;  // R6
          end
        ees_pkg::PS_DRIVE:
          if (pulse_cnt_reg == 4'h0)
            ps_reg <= ees_pkg::PS_IDLE;
          else
            pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
        default:
          ps_reg <= ees_pkg::PS_IDLE;
      endcase
    end
  end

  // pin drive: output data held low, only the enable toggles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shared_stop_line_o  <= 1'b0;
      shared_stop_line_oe <= 1'b0;
    end
    else
    begin
      shared_stop_line_o  <= 1'b0;                               // R19
      shared_stop_line_oe <= (ps_reg == ees_pkg::PS_IDLE && pulse_req)
        || (ps_reg == ees_pkg::PS_DRIVE
            && pulse_cnt_reg != 4'h0);                          // R5 R19
    end
  end

  // error cause: set wins over the clear that a read performs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      err_reg <= 32'h0000_0000;
    else
    begin
      if (rd_fire && s_axi_araddr == `EES_ERR_CAUSE_OFS)
        err_reg <= 32'h0000_0000;
      if (|line_trig)
        err_reg[`EES_LINE_ERR_BIT] <= 1'b1;  // R11
      if (emg_event)
        err_reg[`EES_EMG_ERR_BIT] <= 1'b1;   // R16
    end
  end

  // interrupt level and start inhibit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq           <= 1'b0;
      start_inhibit <= 1'b0;
    end
    else
    begin
      irq           <= |(err_reg & mask_reg);  // R14
      start_inhibit <= emg_act_reg;            // R13
    end
  end

  a_pulse_len: assert property (  // R6
    @(posedge aclk) disable iff (!aresetn)
    $rose(shared_stop_line_oe) |-> shared_stop_line_oe[*8]
    ##1 !shared_stop_line_oe)
    else $error("stop line pulse is not eight clocks");
  a_cmd_drives: assert property (  // R6
    @(posedge aclk) disable iff (!aresetn)
    cmd_sim_stop && ps_reg == ees_pkg::PS_IDLE |=> shared_stop_line_oe)
    else $error("simultaneous stop did not drive the line");
  a_auto_drive: assert property (  // R7
    @(posedge aclk) disable iff (!aresetn)
    (|auto_req) && ps_reg == ees_pkg::PS_IDLE |=> shared_stop_line_oe)
    else $error("error stop did not drive the line");
  a_drive_low: assert property (  // R19
    @(posedge aclk) disable iff (!aresetn)
    !shared_stop_line_o)
    else $error("stop line driven high");
  a_axis_quiet: assert property (  // R9
    @(posedge aclk) disable iff (!aresetn)
    cmd_axis_stop && ps_reg == ees_pkg::PS_IDLE && !(|auto_req)
    |=> !shared_stop_line_oe)
    else $error("axis stop command drove the line");
  a_line_status: assert property (  // R10
    @(posedge aclk) disable iff (!aresetn)
    !line_s2 && !line_s3 |=> ##1 line_act_reg)
    else $error("line status missed a low level");
  a_line_cause: assert property (  // R11
    @(posedge aclk) disable iff (!aresetn)
    (|line_trig) |=> err_reg[`EES_LINE_ERR_BIT])
    else $error("line stop cause not recorded");
  a_emg_all: assert property (  // R12
    @(posedge aclk) disable iff (!aresetn)
    emg_event |=> &stop_immediate)
    else $error("emergency did not stop every axis");
  a_emg_cause: assert property (  // R16
    @(posedge aclk) disable iff (!aresetn)
    emg_event |=> err_reg[`EES_EMG_ERR_BIT])
    else $error("emergency cause not recorded");
  a_emg_inhibit: assert property (  // R13
    @(posedge aclk) disable iff (!aresetn)
    emg_act_reg |=> start_inhibit)
    else $error("start not inhibited during emergency");
  a_emg_irq: assert property (  // R14
    @(posedge aclk) disable iff (!aresetn)
    emg_event && mask_reg[`EES_EMG_ERR_BIT] |=> ##1 irq)
    else $error("emergency interrupt missing");
  a_emg_status: assert property (  // R15
    @(posedge aclk) disable iff (!aresetn)
    !emg_lvl_reg |=> emg_act_reg)
    else $error("emergency status not reported");

endmodule // ees_top

/* sim/ees_line_partner.sv */
// model of another controller or an external open-collector stop driver
`timescale 1ns/10ps
module ees_line_partner (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench request: hold the line low for hold_cycles clocks
  input  wire logic       fire,
  input  wire logic [7:0] hold_cycles,
  // open-collector sink, high while the line is pulled low
  output logic            pull_low
);
  logic [7:0] left_reg;  // clocks still to hold low

  // counts the low pulse down; it can only sink, never drive high,
  // so an idle line floats up to the pull-up level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      left_reg <= 8'h00;
    else if (fire)
      left_reg <= hold_cycles;
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;
  end

  assign pull_low = (left_reg != 8'h00);
endmodule // ees_line_partner

/* sim/external_and_emergency_stop_tb_top.sv */
// self-checking bench for the external and emergency stop block
`timescale 1ns/10ps
`include "ees_params.svh"
module external_and_emergency_stop_tb_top;
  // bus side
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  // pins and axis side; running and speed kind are fixed for the run
  logic        line, line_o, line_oe, pull_low;
  logic        fire = 1'b0;
  logic [7:0]  hold_cycles = 8'h04;
  logic        emergency_input_n = 1'b1;
  logic [3:0]  axis_running = 4'b1111;
  logic [3:0]  axis_high_speed = 4'b1011;
  logic [3:0]  axis_error_stop = 4'b0000;
  logic [3:0]  stop_immediate, stop_decel;
  logic        start_inhibit, irq;
  // monitors
  logic        clr = 1'b1;
  logic        was_oe;
  logic [3:0]  seen_imm, seen_dec;
  logic [7:0]  oe_cnt, oe_rise;
  int          bad_count = 0;
  int          num_checks = 0;
  // axis set-up: line enable, decel method; axis 0 alone has auto-out
  localparam logic [3:0]  EN = 4'b0111;
  localparam logic [3:0]  MTH = 4'b1110;
  localparam logic [3:0]  HS = 4'b1011;
  localparam logic [31:0] CL = 32'h0000_0001 << `EES_LINE_ERR_BIT;
  localparam logic [31:0] CE = 32'h0000_0001 << `EES_EMG_ERR_BIT;
  localparam logic [1:0]  OK = ees_pkg::RESP_OKAY;

  // open-drain wire with pull-up: low if any party sinks it
  assign line = (line_oe ? line_o : 1'b1) & ~pull_low;

  ees_top #(.NUM_AXES(4)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .shared_stop_line_i(line),
    .shared_stop_line_o(line_o), .shared_stop_line_oe(line_oe),
    .emergency_input_n, .axis_running, .axis_high_speed,
    .axis_error_stop, .stop_immediate, .stop_decel, .start_inhibit,
    .irq);
  ees_line_partner far (.aclk, .aresetn, .fire, .hold_cycles, .pull_low);

  always #4 aclk = ~aclk;

  // sticky record of stop pulses and of own line drive since a clear
  always @(posedge aclk)
  begin
    was_oe <= line_oe;
    seen_imm <= clr ? 4'h0 : seen_imm | stop_immediate;
    seen_dec <= clr ? 4'h0 : seen_dec | stop_decel;
    oe_cnt <= clr ? 8'h00 : oe_cnt + {7'h00, line_oe};
    oe_rise <= clr ? 8'h00 : oe_rise + {7'h00, line_oe & ~was_oe};
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    bit aw = 1'b1;
    bit w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(e), 32'(s_axi_bresp));
  endtask

  // one read, data and response compared with the expected pair
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    bit ar = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      ar = ar && !s_axi_arready;
      s_axi_arvalid <= ar;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    chk("rdata", e, s_axi_rdata);
  endtask

  task automatic clear_seen();
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
  endtask

  // idle status, unmapped access, mask read-back, axis set-up
  task automatic t_regs();
    rd(`EES_EXT_STS_OFS, 32'h0000_0000, OK);
    rd(`EES_ERR_CAUSE_OFS, 32'h0000_0000, OK);
    rd(8'h1c, 32'h0000_0000, ees_pkg::RESP_SLVERR);
    wr(8'h1c, 32'h0000_0001, ees_pkg::RESP_SLVERR);
    wr(`EES_IRQ_MASK_OFS, CL | CE, OK);
    rd(`EES_IRQ_MASK_OFS, CL | CE, OK);
    for (int i = 0; i < 4; i++)
    begin
      wr(`EES_AXIS_BASE + `EES_AXIS_STRIDE * 8'(i),
         (32'(EN[i]) << `EES_LINE_EN_BIT) |
         (32'(i == 0) << `EES_AUTO_OUT_BIT), OK);
      wr(`EES_AXIS_BASE + `EES_AXIS_STRIDE * 8'(i) + `EES_ENV1_OFS,
         32'(MTH[i]) << `EES_STOP_MTH_BIT, OK);
    end
  endtask

  // shortest legal external pulse stops enabled axes by method and speed
  task automatic t_line();
    clear_seen();
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (20) @(posedge aclk);
    chk("imm", 32'(EN & ~(MTH & HS)), 32'(seen_imm));
    chk("dec", 32'(EN & MTH & HS), 32'(seen_dec));
    chk("oe", 32'h0000_0000, 32'(oe_cnt));
    chk("irq", 32'h0000_0001, 32'(irq));
    rd(`EES_ERR_CAUSE_OFS, CL, OK);
    repeat (3) @(posedge aclk);
    chk("irq", 32'h0000_0000, 32'(irq));
    hold_cycles <= 8'h28;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(`EES_EXT_STS_OFS, 32'h0000_0001 << `EES_LINE_STS_BIT, OK);
    repeat (40) @(posedge aclk);
    rd(`EES_EXT_STS_OFS, 32'h0000_0000, OK);
    rd(`EES_ERR_CAUSE_OFS, CL, OK);
  endtask

  // own one-shot from a command or an auto-out error stop
  task automatic t_pulse(input bit by_err);
    clear_seen();
    if (by_err)
    begin
      axis_error_stop <= 4'b1000;
      @(posedge aclk);
      axis_error_stop <= 4'b0000;
      repeat (15) @(posedge aclk);
      chk("no auto", 32'h0000_0000, 32'(oe_cnt));
      axis_error_stop <= 4'b0001;
      @(posedge aclk);
      axis_error_stop <= 4'b0000;
    end
    else
      wr(`EES_CMD_OFS, 32'(`EES_CMD_SIM_STOP), OK);
    repeat (20) @(posedge aclk);
    chk("oe len", 32'h0000_0008, 32'(oe_cnt));
    chk("oe rise", 32'h0000_0001, 32'(oe_rise));
    chk("imm", 32'(EN & ~(MTH & HS)), 32'(seen_imm));
    rd(`EES_ERR_CAUSE_OFS, CL, OK);
  endtask

  // single-axis stop command leaves the shared line alone
  task automatic t_axis_cmd();
    clear_seen();
    wr(`EES_CMD_OFS, 32'h0000_0800 | 32'(`EES_CMD_AXIS_STOP), OK);
    repeat (15) @(posedge aclk);
    chk("imm", 32'h0000_0008, 32'(seen_imm));
    chk("oe", 32'h0000_0000, 32'(oe_cnt));
    rd(`EES_ERR_CAUSE_OFS, 32'h0000_0000, OK);
  endtask

  // emergency pin low, then the command with its interrupt masked
  task automatic t_emg();
    int n;
    clear_seen();
    emergency_input_n <= 1'b0;
    for (n = 0; n < 30 && start_inhibit !== 1'b1; n++)
      @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk("inhibit", 32'h0000_0001, 32'(start_inhibit));
    chk("imm", 32'(axis_running), 32'(seen_imm));
    chk("irq", 32'h0000_0001, 32'(irq));
    rd(`EES_EXT_STS_OFS, 32'h0000_0001 << `EES_EMG_STS_BIT, OK);
    rd(`EES_ERR_CAUSE_OFS, CE, OK);
    emergency_input_n <= 1'b1;
    repeat (15) @(posedge aclk);
    chk("inhibit", 32'h0000_0000, 32'(start_inhibit));
    wr(`EES_IRQ_MASK_OFS, 32'h0000_0000, OK);
    clear_seen();
    wr(`EES_CMD_OFS, 32'(`EES_CMD_EMG), OK);
    repeat (4) @(posedge aclk);
    chk("imm", 32'(axis_running), 32'(seen_imm));
    chk("irq", 32'h0000_0000, 32'(irq));
    rd(`EES_ERR_CAUSE_OFS, CE, OK);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    clr <= 1'b0;
    t_regs();
    t_line();
    t_pulse(1'b0);
    t_pulse(1'b1);
    t_axis_cmd();
    t_emg();
    give_verdict();
  end

  // watchdog far beyond the few hundred clocks the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    give_verdict();
  end
endmodule // external_and_emergency_stop_tb_top
